// ===== common/osc_defs.vh
// Constants for the oscillator source control block
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

`define OSC_ADDR_CTRL      4'h0
`define OSC_ADDR_TRIM      4'h4
`define OSC_ADDR_CFG       4'h8
`define OSC_ADDR_STAT      4'hc

`define OSC_FREQ_RST       3'h6
`define OSC_FREQ_SLOW      3'h0
`define OSC_FREQ_TOP       3'h7
`define OSC_TRIM_RST       5'h00
`define OSC_MODE_RST       3'h7

`define OSC_MODE_SLOW_XTAL 3'h0
`define OSC_MODE_MED_XTAL  3'h1
`define OSC_MODE_HIGH_XTAL 3'h2
`define OSC_MODE_DRIVEN    3'h3
`define OSC_MODE_INT_IO    3'h4
`define OSC_MODE_INT_OUT   3'h5
`define OSC_MODE_RC_IO     3'h6
`define OSC_MODE_RC_OUT    3'h7

`define OSC_GAIN_OFF       2'h0
`define OSC_GAIN_LOW       2'h1
`define OSC_GAIN_MED       2'h2
`define OSC_GAIN_HIGH      2'h3

`define OSC_XTAL_COUNT     11'd1024
`define OSC_WARM_NS        2000
`define OSC_CLK_NS         100
`define OSC_STABLE_CYC     8'd16

`define OSC_RESP_OKAY      2'h0
`define OSC_RESP_SLVERR    2'h2

`endif

// ===== design/osc_source_ctrl.v
// Oscillator source selection, start-up counting and clock output control
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "osc_defs.vh"

module osc_source_ctrl #(
	parameter CNT_W = 11
) (
	input  wire        clk_in,         // System clock 10 MHz
	input  wire        rstn_in,        // Async reset, active low
	input  wire        wake_in,        // Wake from sleep pulse
	input  wire        power_up_delay_timer_done_in,   // Power-up delay finished level
	input  wire        pin_clk_in,     // Primary pin level, synchronous
	input  wire [31:0] s_axi_awaddr,   // Write address
	input  wire        s_axi_awvalid,  // Write address valid
	output reg         s_axi_awready,  // Write address ready
	input  wire [31:0] s_axi_wdata,    // Write data
	input  wire [3:0]  s_axi_wstrb,    // Write strobes
	input  wire        s_axi_wvalid,   // Write data valid
	output reg         s_axi_wready,   // Write data ready
	output reg  [1:0]  s_axi_bresp,    // Write response
	output reg         s_axi_bvalid,   // Write response valid
	input  wire        s_axi_bready,   // Write response ready
	input  wire [31:0] s_axi_araddr,   // Read address
	input  wire        s_axi_arvalid,  // Read address valid
	output reg         s_axi_arready,  // Read address ready
	output reg  [31:0] s_axi_rdata,    // Read data
	output reg  [1:0]  s_axi_rresp,    // Read response
	output reg         s_axi_rvalid,   // Read data valid
	input  wire        s_axi_rready,   // Read data ready
	output reg         run_out,        // Execution allowed
	output reg         use_internal_out, // System clock from inside
	output reg  [2:0]  freq_sel_out,   // Active postscaler code
	output reg         fast_en_out,    // Fast oscillator enable
	output reg  [4:0]  fast_trim_out,  // Fast oscillator trim
	output reg  [1:0]  amp_gain_out,   // Amplifier gain
	output reg         pin1_io_out,    // Primary pin free for I/O
	output reg         pin2_io_out,    // Second pin free for I/O
	output reg         divided_clock_output_out,     // Divided clock output
	output reg         divided_clock_output_oe_n_out // Low while driving divided_clock_output
);

	localparam [CNT_W-1:0] START_CNT = `OSC_XTAL_COUNT;
	localparam integer WARM_CYC_I =
		(`OSC_WARM_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS;
	localparam [CNT_W-1:0] WARM_CNT = WARM_CYC_I[CNT_W-1:0];

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_FALL = 4'h2;
	localparam [3:0] ST_HOLD = 4'h4;
	localparam [3:0] ST_RISE = 4'h8;

	reg  [2:0]       freq_q;
	reg              sel_int_q;
	reg  [4:0]       trim_q;
	reg  [2:0]       mode_q;
	reg              two_speed_q;
	reg  [CNT_W-1:0] cnt_q;
	reg              counting_q;
	reg              pin_prev_q;
	reg  [7:0]       stab_q;
	reg  [2:0]       act_freq_q;
	reg  [3:0]       sw_q;
	reg  [7:0]       div_q;
	reg              ext_q;
	reg              aw_hold_q;
	reg              w_hold_q;
	reg  [31:0]      awaddr_q;
	reg  [31:0]      wdata_q;
	reg  [3:0]       wstrb_q;

	wire xtal_mode = (mode_q == `OSC_MODE_SLOW_XTAL) ||
		(mode_q == `OSC_MODE_MED_XTAL) ||
		(mode_q == `OSC_MODE_HIGH_XTAL);
	wire int_mode = (mode_q == `OSC_MODE_INT_IO) ||
		(mode_q == `OSC_MODE_INT_OUT);
	wire internal = sel_int_q || int_mode;
	wire fast_en = (freq_q != `OSC_FREQ_SLOW) &&
		(sel_int_q || two_speed_q || int_mode);
	wire trigger = wake_in || (power_up_delay_timer_done_in && !ext_q);
	wire pin_rise = pin_clk_in && !pin_prev_q;
	wire stable = (stab_q == `OSC_STABLE_CYC);
	// One postscaler tap per frequency code; the top code taps bit 1 (/4).
	// The slow code shares the slowest tap, since clk_in has nothing slower.
	wire [7:0] post_div4;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_tap
			if (gi == 0) begin : g_slow
				assign post_div4[gi] = div_q[7];
			end else begin : g_fast
				assign post_div4[gi] = div_q[8 - gi];
			end
		end
	endgenerate
	wire clk_div4 = post_div4[act_freq_q];

	// Start-up sequencing; ext_q marks the first release after power-up
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q      <= {CNT_W{1'b0}};
			counting_q <= 1'b0;
			pin_prev_q <= 1'b0;
			ext_q      <= 1'b0;
		end else begin
			pin_prev_q <= pin_clk_in;
			if (trigger) begin
				ext_q <= 1'b1;
				cnt_q <= {CNT_W{1'b0}};
				counting_q <= !(mode_q == `OSC_MODE_DRIVEN ||
					mode_q == `OSC_MODE_RC_IO ||
					mode_q == `OSC_MODE_RC_OUT) || internal;
			end else if (counting_q) begin
				if (internal) begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 == WARM_CNT)
						counting_q <= 1'b0;
				end else if (xtal_mode && pin_rise) begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 == START_CNT)
						counting_q <= 1'b0;
				end
			end
		end
	end

	// Clock switch: wait falling edge, hold output low, resume on rising
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sw_q       <= ST_IDLE;
			act_freq_q <= `OSC_FREQ_RST;
			div_q      <= 8'h00;
			stab_q     <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
			if (!fast_en)
				stab_q <= 8'h00;
			else if (!stable)
				stab_q <= stab_q + 8'h01;
			case (sw_q)
			ST_IDLE: if (act_freq_q != freq_q)
				sw_q <= ST_FALL;
			ST_FALL: if (clk_div4) begin
				sw_q <= ST_HOLD;
			end
			ST_HOLD: if (freq_q == `OSC_FREQ_SLOW || stable) begin
				act_freq_q <= freq_q;
				sw_q <= ST_RISE;
			end
			ST_RISE: if (!clk_div4)
				sw_q <= ST_IDLE;
			default: sw_q <= ST_IDLE;
			endcase
		end
	end

	// Outputs, all registered
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_out          <= 1'b0;
			use_internal_out <= 1'b0;
			freq_sel_out     <= `OSC_FREQ_RST;
			fast_en_out      <= 1'b0;
			fast_trim_out    <= `OSC_TRIM_RST;
			amp_gain_out     <= `OSC_GAIN_OFF;
			pin1_io_out      <= 1'b0;
			pin2_io_out      <= 1'b0;
			divided_clock_output_out       <= 1'b0;
			divided_clock_output_oe_n_out  <= 1'b1;
		end else begin
			run_out          <= ext_q && !counting_q && !trigger;
			use_internal_out <= internal;
			freq_sel_out     <= act_freq_q;
			fast_en_out      <= fast_en;
			fast_trim_out    <= trim_q;
			case (mode_q)
			`OSC_MODE_SLOW_XTAL: amp_gain_out <= `OSC_GAIN_LOW;
			`OSC_MODE_MED_XTAL:  amp_gain_out <= `OSC_GAIN_MED;
			`OSC_MODE_HIGH_XTAL: amp_gain_out <= `OSC_GAIN_HIGH;
			default:             amp_gain_out <= `OSC_GAIN_OFF;
			endcase
			pin1_io_out <= int_mode;
			pin2_io_out <= (mode_q == `OSC_MODE_DRIVEN) ||
				(mode_q == `OSC_MODE_RC_IO) ||
				(mode_q == `OSC_MODE_INT_IO);
			divided_clock_output_oe_n_out <= !((mode_q == `OSC_MODE_RC_OUT) ||
				(mode_q == `OSC_MODE_INT_OUT));
			divided_clock_output_out <= (sw_q == ST_HOLD || sw_q == ST_RISE) ?
				1'b0 : clk_div4;
		end
	end

	// AXI4-Lite write side: address and data accepted in either order
	wire [31:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
	wire [3:0]  ws = w_hold_q ? wstrb_q : s_axi_wstrb;
	// Upper address bits must be zero, so the map does not alias
	wire wr_top = (wa[31:4] == 28'h0000000);
	wire rd_top = (s_axi_araddr[31:4] == 28'h0000000);
	wire wr_hit = wr_top && ((wa[3:0] == `OSC_ADDR_CTRL) ||
		(wa[3:0] == `OSC_ADDR_TRIM) || (wa[3:0] == `OSC_ADDR_CFG));

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `OSC_RESP_OKAY;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 32'h00000000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			freq_q        <= `OSC_FREQ_RST;
			sel_int_q     <= 1'b0;
			trim_q        <= `OSC_TRIM_RST;
			mode_q        <= `OSC_MODE_RST;
			two_speed_q   <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
				if (ws[0] && wr_hit) begin
					case (wa[3:0])
					`OSC_ADDR_CTRL: begin
						freq_q    <= wd[6:4];
						sel_int_q <= wd[0];
					end
					`OSC_ADDR_TRIM: trim_q <= wd[4:0];
					`OSC_ADDR_CFG: begin
						mode_q      <= wd[2:0];
						two_speed_q <= wd[3];
					end
					default: ;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read side: one cycle after the address is taken
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `OSC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `OSC_RESP_OKAY;
				case ({!rd_top, s_axi_araddr[3:0]})
				{1'b0, `OSC_ADDR_CTRL}: s_axi_rdata <= {25'h0, freq_q,
					!internal, stable, 1'b1, sel_int_q};
				{1'b0, `OSC_ADDR_TRIM}: s_axi_rdata <= {27'h0, trim_q};
				{1'b0, `OSC_ADDR_CFG}:  s_axi_rdata <= {28'h0, two_speed_q,
					mode_q};
				{1'b0, `OSC_ADDR_STAT}: s_axi_rdata <= {26'h0, sw_q,
					counting_q, run_out};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `OSC_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Not fully static: the warm-up count cnt_q and the stability count stab_q depend on elapsed clk_in cycles.

endmodule // osc_source_ctrl

// ===== verif/osc_xtal_model.sv
// Behavioural crystal or driven clock on the primary clock pin
`timescale 1ns/1ps
module osc_xtal_model (
	input  wire logic       clk_in,  // Bench clock
	input  wire logic       en_in,   // Oscillator running
	input  wire logic [1:0] half_in, // Half period in clocks, less one
	output logic            pin_out  // Primary pin level
);
	logic [1:0] cnt_q = 2'h0;
	initial pin_out = 1'h0;
	// Stands low when stopped, so no stray edge is counted
	always @(posedge clk_in) begin
		if (!en_in) begin
			pin_out <= 1'h0;
			cnt_q <= 2'h0;
		end else if (cnt_q == half_in) begin
			pin_out <= !pin_out;
			cnt_q <= 2'h0;
		end else
			cnt_q <= cnt_q + 2'h1;
	end
endmodule // osc_xtal_model

// ===== verif/osc_chk_assertions.sv
// Port-level property checks for the oscillator source control
`timescale 1ns/1ps
module osc_chk (
	input wire logic        clk_in, rstn_in, wake_in, run_out,
	input wire logic        use_internal_out, pin1_io_out, pin2_io_out,
	input wire logic        divided_clock_output_out, divided_clock_output_oe_n_out, s_axi_bvalid,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  amp_gain_out, s_axi_rresp,
	input wire logic [2:0]  freq_sel_out,
	input wire logic [4:0]  fast_trim_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_reset_vals: assert property (
		$rose(rstn_in) |-> !run_out && freq_sel_out == 3'h6 &&
		fast_trim_out == 5'h00) else $error("Bad values after reset");
	a_wake_halts: assert property (
		wake_in |=> !run_out) else $error("Run kept after wake");
	a_xtal_pins: assert property (
		amp_gain_out != 2'h0 |-> !pin1_io_out && !pin2_io_out &&
		divided_clock_output_oe_n_out) else $error("Crystal pins freed");
	a_out_pin: assert property (
		!divided_clock_output_oe_n_out |-> !pin2_io_out) else $error("Pin two clash");
	a_pin1_int: assert property (
		pin1_io_out |-> use_internal_out) else $error("Pin one freed");
	a_trim_write: assert property (
		$changed(fast_trim_out) |-> $past(s_axi_bvalid))
		else $error("Trim moved without write");
	a_trim_run: assert property (
		$changed(fast_trim_out) && $past(run_out) |-> run_out)
		else $error("Trim stopped execution");
	a_switch_low: assert property (
		$changed(freq_sel_out) |-> !$past(divided_clock_output_out))
		else $error("Switch with clock output high");
	c_run: cover property ($rose(run_out));
	c_switch: cover property ($changed(freq_sel_out));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // osc_chk

// ===== verif/osc_source_ctrl_tb_top.sv
// Self-checking bench for the oscillator source control
`timescale 1ns/1ps
module osc_source_ctrl_tb_top;
	logic        clk_in = 0, rstn_in = 0, wake_in = 0, power_up_delay_timer_done_in = 0;
	logic        xen = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [1:0]  xhalf = 2'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic        pin_clk_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, run_out, use_internal_out;
	logic        fast_en_out, pin1_io_out, pin2_io_out, divided_clock_output_out;
	logic        divided_clock_output_oe_n_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp, amp_gain_out;
	logic [2:0]  freq_sel_out;
	logic [4:0]  fast_trim_out;
	logic [31:0] s_axi_rdata;
	int          err_total = 0, checks = 0;
	always #50 clk_in = ~clk_in;
	osc_source_ctrl dut (.*);
	osc_xtal_model u_xtal (.clk_in(clk_in), .en_in(xen), .half_in(xhalf),
		.pin_out(pin_clk_in));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic sn;
		tick(2);
		@(negedge clk_in);
	endtask
	task automatic ck(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
		input logic [1:0] r);
		logic ta, tw, tb;
		logic [1:0] rs;
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge clk_in);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clk_in);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			n++;
		end while (!tb && n < 40);
		s_axi_bready <= 1'h0;
		ck({tb, rs}, {1'h1, r});
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [31:0] a, m, e, input logic [1:0] r);
		logic ta, tv;
		logic [33:0] v;
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge clk_in);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			v = {s_axi_rresp, s_axi_rdata};
			@(posedge clk_in);
			if (ta) s_axi_arvalid <= 1'h0;
			n++;
		end while (!tv && n < 40);
		s_axi_rready <= 1'h0;
		ck({tv, v[33:32]}, {1'h1, r});
		ck(v[31:0] & m, e);
		@(posedge clk_in);
	endtask
	task automatic wrun(input int lim);
		int n;
		n = 0;
		do @(negedge clk_in); while (run_out !== 1'h1 && ++n < lim);
		ck(run_out, 1'h1);
		@(posedge clk_in);
	endtask
	task automatic wfs(input logic [2:0] e);
		int n;
		n = 0;
		do @(negedge clk_in); while (freq_sel_out !== e && ++n < 64);
		ck(freq_sel_out, e);
		@(posedge clk_in);
	endtask
	task automatic wake;
		wake_in <= 1'h1;
		tick(1);
		wake_in <= 1'h0;
	endtask
	task automatic t_reset;
		rd(32'h0, 32'h77, 32'h62, 2'h0);
		rd(32'h4, 32'hff, 32'h0, 2'h0);
		rd(32'h8, 32'hf, 32'h7, 2'h0);
		rd(32'h10, 32'hffffffff, 32'h0, 2'h2);
		power_up_delay_timer_done_in <= 1'h1;
		wrun(12);
	endtask
	task automatic t_xtal;
		for (int m = 0; m < 3; m++) begin
			wr(32'h8, m, 4'hf, 2'h0);
			sn;
			ck({amp_gain_out, pin1_io_out, pin2_io_out},
				(m + 1) << 2);
			tick(1);
		end
		xen <= 1'h1;
		wake;
		repeat (600) @(posedge pin_clk_in);
		xhalf <= 2'h1;
		wake;
		repeat (1023) @(posedge pin_clk_in);
		@(negedge clk_in);
		ck(run_out, 1'h0);
		@(posedge clk_in);
		wrun(12);
		xen <= 1'h0;
	endtask
	task automatic t_drv;
		wr(32'h8, 32'h3, 4'hf, 2'h0);
		wake;
		wrun(6);
		sn;
		ck({pin1_io_out, pin2_io_out, amp_gain_out}, 32'h4);
		tick(1);
	endtask
	task automatic t_modes;
		logic [15:0] lut;
		logic [1:0]  seen;
		lut = 16'h069f;
		for (int i = 0; i < 4; i++) begin
			wr(32'h8, 4 + i, 4'hf, 2'h0);
			sn;
			ck({pin1_io_out, pin2_io_out, divided_clock_output_oe_n_out, use_internal_out},
				lut[4*i +: 4]);
			tick(1);
		end
		seen = 2'h0;
		repeat (8) begin
			@(negedge clk_in);
			seen = seen | (2'h1 << divided_clock_output_out);
		end
		ck(seen, 2'h3);
		@(posedge clk_in);
	endtask
	task automatic t_sel;
		wr(32'h0, 32'h71, 4'hf, 2'h0);
		wfs(3'h7);
		tick(20);
		rd(32'h0, 32'h7f, 32'h77, 2'h0);
		sn;
		ck({use_internal_out, fast_en_out}, 32'h3);
		tick(1);
		wr(32'h0, 32'h01, 4'hf, 2'h0);
		wfs(3'h0);
		sn;
		ck(fast_en_out, 1'h0);
		tick(1);
		wr(32'h0, 32'h60, 4'hf, 2'h0);
		rd(32'h0, 32'h9, 32'h8, 2'h0);
		wr(32'h8, 32'hf, 4'hf, 2'h0);
		sn;
		ck({use_internal_out, fast_en_out}, 32'h1);
		tick(1);
		wr(32'h8, 32'h7, 4'hf, 2'h0);
		sn;
		ck(fast_en_out, 1'h0);
		tick(1);
	endtask
	task automatic t_trim;
		wr(32'h4, 32'hff, 4'hf, 2'h0);
		rd(32'h4, 32'hffffffff, 32'h1f, 2'h0);
		wr(32'h4, 32'h3, 4'h0, 2'h0);
		wr(32'h14, 32'h3, 4'hf, 2'h2);
		sn;
		ck({run_out, fast_trim_out}, 32'h3f);
		tick(1);
	endtask
	task automatic end_sim;
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		end_sim;
	end
	initial begin
		tick(10);
		rstn_in <= 1'h1;
		tick(2);
		t_reset;
		t_xtal;
		t_drv;
		t_modes;
		t_sel;
		t_trim;
		end_sim;
	end
endmodule // osc_source_ctrl_tb_top
bind osc_source_ctrl osc_chk u_chk (.*);
